// file: common/rru_pkg.sv
// constants for the remote register update block
package rru_pkg;
  localparam int          ADDR_W        = 7;
  localparam int          DATA_W        = 8;
  localparam int          NGRP          = 3;
  // register offsets
  localparam logic [6:0]  LNK_UPD_ADDR  = 7'h3E;
  localparam logic [6:0]  TXA_UPD_ADDR  = 7'h5B;
  localparam logic [6:0]  RXC_UPD_ADDR  = 7'h4B;
  localparam logic [6:0]  TX_FMT_ADDR   = 7'h01;
  localparam logic [6:0]  TX_LAT_ADDR   = 7'h02;
  localparam logic [6:0]  I2S_IN_ADDR   = 7'h03;
  localparam logic [6:0]  LNK_MODE_ADDR = 7'h04;
  localparam logic [6:0]  RX_CTL_ADDR   = 7'h05;
  localparam logic [6:0]  RX_MODE_ADDR  = 7'h06;
  localparam logic [6:0]  TX_STA_ADDR   = 7'h07;
  localparam logic [6:0]  RX_PIN_ADDR   = 7'h08;
  localparam logic [6:0]  LINK_ST_ADDR  = 7'h09;
  // status codes
  localparam logic [7:0]  ST_IDLE_OK    = 8'h00;
  localparam logic [7:0]  ST_BUSY       = 8'h01;
  localparam logic [7:0]  ST_IDLE_FAIL  = 8'h02;
  localparam logic [7:0]  CMD_START     = 8'h01;
  localparam int          FORCE_BIT     = 4;
  // group indices
  localparam int          G_LNK         = 0;
  localparam int          G_TXA         = 1;
  localparam int          G_RXC         = 2;
  // frame word layout: [11:10] group/kind, [9:8] field, [7:0] data
  localparam logic [1:0]  K_LOCATE      = 2'h3;
  localparam logic [7:0]  ZERO8         = 8'h00;
  // reply wait budget in cycles
  localparam int          ACK_WAIT_NS   = 2000;
  localparam int          CLK_NS        = 10;
  localparam int          ACK_WAIT_CYC  = ACK_WAIT_NS / CLK_NS;
  typedef enum logic [1:0] {
    RRU_IDLE = 2'b00,
    RRU_SEND = 2'b01,
    RRU_WAIT = 2'b10
  } rru_state_t;
endpackage

// file: hw/rru_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module rru_sync
  import rru_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // a change counts once stages two and three agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1     <= '0;
      s2     <= '0;
      s3     <= '0;
      sync_o <= '0;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          sync_o[i] <= s3[i];
        end
      end
    end
  end
endmodule

// file: hw/rru_top.sv
// transmitter-side remote register update engine
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
module rru_top
  import rru_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // radio control channel
  output logic      [11:0]       frame_o,
  output logic                   frame_valid_o,
  input  wire logic              frame_ready_i,
  input  wire logic              ack_i,
  input  wire logic              nack_i,
  input  wire logic              link_up_i,
  input  wire logic              locate_i,
  input  wire logic [7:0]        rx_pins_i,
  // applied configuration and reconfiguration
  output logic      [7:0]        tx_fmt_active_o,
  output logic      [7:0]        tx_lat_active_o,
  output logic      [7:0]        i2s_in_active_o,
  output logic                   reconfig_o,
  output logic                   relink_req_o
);
  // registers
  logic [7:0]  tx_fmt;
  logic [7:0]  tx_lat;
  logic [7:0]  i2s_in;
  logic [7:0]  lnk_mode;
  logic [7:0]  rx_ctl;
  logic [7:0]  rx_mode;
  logic [7:0]  tx_sta;
  logic [7:0]  status [NGRP];
  rru_state_t  state;
  rru_state_t  next_state;
  logic [1:0]  grp;
  logic [1:0]  fld;
  logic [8:0]  wait_cnt;
  logic        link_q;
  logic [7:0]  pins_s;
  logic        link_s;
  logic        locate_s;
  logic        locate_q;
  logic        locate_pend;
  logic        ack_s;
  logic        nack_s;

  // far-end inputs cross in from the radio domain
  rru_sync #(.W(12)) u_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   ({rx_pins_i, link_up_i, locate_i, ack_i, nack_i}),
    .sync_o    ({pins_s, link_s, locate_s, ack_s, nack_s})
  );

  // decode
  wire       hit_lnk   = addr_i == LNK_UPD_ADDR;
  wire       hit_txa   = addr_i == TXA_UPD_ADDR;
  wire       hit_rxc   = addr_i == RXC_UPD_ADDR;
  wire       start_cmd = wr_i && (wdata_i == CMD_START);
  wire       idle_fsm  = state == RRU_IDLE;
  wire [2:0] grp_idle  = {status[G_RXC] != ST_BUSY, status[G_TXA] != ST_BUSY,
                          status[G_LNK] != ST_BUSY};
  wire [2:0] trig      = {hit_rxc, hit_txa, hit_lnk} & {3{start_cmd}} & grp_idle;
  // buffers writable only while the group is idle
  wire       wr_txa_ok = wr_i && grp_idle[G_TXA];
  wire       wr_lnk_ok = wr_i && grp_idle[G_LNK];
  wire       wr_rxc_ok = wr_i && grp_idle[G_RXC];
  wire       link_rise = link_s && !link_q;
  wire       locate_rise = locate_s && !locate_q;
  // pending group, lowest index first
  wire [2:0] busy_vec  = {status[G_RXC] == ST_BUSY, status[G_TXA] == ST_BUSY,
                          status[G_LNK] == ST_BUSY};
  wire [1:0] pick      = busy_vec[0] ? 2'd0 : (busy_vec[1] ? 2'd1 : 2'd2);
  wire       any_pend  = (|busy_vec) || locate_pend;
  wire       timeout   = wait_cnt == 9'(ACK_WAIT_CYC);
  // locate burst carries two fields, audio three, the other groups one
  wire       last_fld  = (grp == 2'(G_TXA)) ? (fld == 2'd2) :
                         ((grp == K_LOCATE) ? (fld == 2'd1) : (fld == 2'd0));
  // a frame counts as sent only when the offered frame meets ready
  wire       xfer      = frame_valid_o && frame_ready_i;

  // field mux: hop table is not part of any group
  logic [7:0] fdata;
  always_comb begin
    fdata = ZERO8;
    case (grp)
      2'(G_LNK): fdata = lnk_mode;
      2'(G_TXA): fdata = (fld == 2'd0) ? tx_fmt : ((fld == 2'd1) ? tx_lat : i2s_in);
      2'(G_RXC): fdata = rx_ctl;
      K_LOCATE:  fdata = (fld == 2'd0) ? tx_sta : rx_mode;
      default:   fdata = ZERO8;
    endcase
  end

  always_comb begin
    next_state = state;
    case (state)
      RRU_IDLE: if (any_pend) next_state = RRU_SEND;
      RRU_SEND: if (xfer && last_fld) next_state = RRU_WAIT;
      RRU_WAIT: if (ack_s || nack_s || timeout) next_state = RRU_IDLE;
      default:  next_state = RRU_IDLE;
    endcase
  end

  // control bus writes; values stay buffered until sent
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_fmt   <= ZERO8;
      tx_lat   <= ZERO8;
      i2s_in   <= ZERO8;
      lnk_mode <= ZERO8;
      rx_ctl   <= ZERO8;
      rx_mode  <= ZERO8;
      tx_sta   <= ZERO8;
    end else begin
      if (wr_txa_ok && addr_i == TX_FMT_ADDR) tx_fmt <= wdata_i;
      if (wr_txa_ok && addr_i == TX_LAT_ADDR) tx_lat <= wdata_i;
      if (wr_txa_ok && addr_i == I2S_IN_ADDR) i2s_in <= wdata_i;
      if (wr_lnk_ok && addr_i == LNK_MODE_ADDR) lnk_mode <= wdata_i;
      if (wr_rxc_ok && addr_i == RX_CTL_ADDR) rx_ctl <= wdata_i;
      if (wr_i && addr_i == RX_MODE_ADDR) rx_mode <= wdata_i;
      if (wr_i && addr_i == TX_STA_ADDR) tx_sta <= wdata_i;
      if (relink_req_o) lnk_mode[FORCE_BIT] <= 1'b0; // self-clearing
    end
  end

  // per-group status; hardware result wins over a host write
  generate
    for (genvar g = 0; g < NGRP; g++) begin : g_stat
      wire done_g = (state == RRU_WAIT) && (grp == 2'(g));
      always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          status[g] <= ST_IDLE_OK;
        end else if (done_g && ack_s) begin
          status[g] <= ST_IDLE_OK;
        end else if (done_g && (nack_s || timeout)) begin
          status[g] <= ST_IDLE_FAIL;
        end else if (trig[g]) begin
          status[g] <= ST_BUSY;
        end
      end
    end
  endgenerate

  // transfer engine
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state       <= RRU_IDLE;
      grp         <= 2'd0;
      fld         <= 2'd0;
      wait_cnt    <= 9'd0;
      link_q      <= 1'b0;
      locate_q    <= 1'b0;
      locate_pend <= 1'b0;
    end else begin
      state    <= next_state;
      link_q   <= link_s;
      locate_q <= locate_s;
      if (locate_rise) locate_pend <= 1'b1;
      else if (idle_fsm && locate_pend && !(|busy_vec)) locate_pend <= 1'b0;
      if (idle_fsm) begin
        grp      <= (|busy_vec) ? pick : K_LOCATE;
        fld      <= 2'd0;
        wait_cnt <= 9'd0;
      end else if (state == RRU_SEND && xfer && !last_fld) begin
        fld <= fld + 2'd1;
      end else if (state == RRU_WAIT) begin
        wait_cnt <= wait_cnt + 9'd1;
      end
    end
  end

  // outputs and reconfiguration
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_o         <= 12'h000;
      frame_valid_o   <= 1'b0;
      tx_fmt_active_o <= ZERO8;
      tx_lat_active_o <= ZERO8;
      i2s_in_active_o <= ZERO8;
      reconfig_o      <= 1'b0;
      relink_req_o    <= 1'b0;
    end else begin
      // offer one frame, hold it until taken, then one gap cycle to load the next
      frame_valid_o <= (state == RRU_SEND) && !xfer;
      if (!frame_valid_o) frame_o <= {grp, fld, fdata};
      relink_req_o  <= lnk_mode[FORCE_BIT] && !relink_req_o;
      reconfig_o    <= link_rise;
      if (link_rise) begin
        tx_fmt_active_o <= tx_fmt;
        tx_lat_active_o <= tx_lat;
        i2s_in_active_o <= i2s_in;
      end
    end
  end

  // read path, one cycle latency
  logic [7:0] rsel;
  always_comb begin
    rsel = ZERO8;
    case (addr_i)
      LNK_UPD_ADDR:  rsel = status[G_LNK];
      TXA_UPD_ADDR:  rsel = status[G_TXA];
      RXC_UPD_ADDR:  rsel = status[G_RXC];
      TX_FMT_ADDR:   rsel = tx_fmt;
      TX_LAT_ADDR:   rsel = tx_lat;
      I2S_IN_ADDR:   rsel = i2s_in;
      LNK_MODE_ADDR: rsel = lnk_mode;
      RX_CTL_ADDR:   rsel = rx_ctl;
      RX_MODE_ADDR:  rsel = rx_mode;
      TX_STA_ADDR:   rsel = tx_sta;
      RX_PIN_ADDR:   rsel = pins_s;
      LINK_ST_ADDR:  rsel = {6'h00, locate_s, link_s};
      // slave strap and master-execute live in the receiver; nothing held here
      default:       rsel = ZERO8;
    endcase
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) rdata_o <= ZERO8;
    else            rdata_o <= rd_i ? rsel : ZERO8;
  end

  // checks
  start_busy_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (wr_i && hit_txa && wdata_i == CMD_START && grp_idle[G_TXA])
      |=> status[G_TXA] == ST_BUSY) else $error("start did not go busy");
  ack_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (state == RRU_WAIT && ack_s && grp == 2'(G_LNK)) |=> status[G_LNK] == ST_IDLE_OK)
    else $error("ack did not clear status");
  fail_mark_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (state == RRU_WAIT && !ack_s && nack_s && grp == 2'(G_RXC))
      |=> status[G_RXC] == ST_IDLE_FAIL) else $error("nack not reported");
  busy_read_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (rd_i && hit_txa && status[G_TXA] == ST_BUSY) |=> rdata_o == ST_BUSY)
    else $error("busy not read back");
  other_value_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (wr_i && hit_lnk && wdata_i != CMD_START && state != RRU_WAIT)
      |=> $stable(status[G_LNK])) else $error("non-start write changed status");
  buffer_lock_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (wr_i && addr_i == TX_FMT_ADDR && status[G_TXA] == ST_BUSY) |=> $stable(tx_fmt))
    else $error("buffer written while busy");
  wait_bound_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (state == RRU_WAIT) |-> ##[0:201] (state == RRU_IDLE))
    else $error("wait exceeded budget");
  relink_pulse_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    $rose(lnk_mode[FORCE_BIT]) |=> relink_req_o ##1 !relink_req_o)
    else $error("force bit gave no relink");
  reconfig_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    link_rise |=> reconfig_o && tx_fmt_active_o == $past(tx_fmt))
    else $error("link up without reconfig");
  valid_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (frame_valid_o && !frame_ready_i) |=> frame_valid_o && $stable(frame_o))
    else $error("offered frame dropped or changed");
  locate_two_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (state == RRU_SEND && grp == K_LOCATE && xfer && fld == 2'd0) |=> state == RRU_SEND)
    else $error("locate burst cut short");
  fmt_frame_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (frame_valid_o && frame_o[11:10] == 2'(G_TXA) && frame_o[9:8] == 2'd0)
      |-> frame_o[7:0] == tx_fmt) else $error("audio frame carries wrong format");
  rxc_frame_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (frame_valid_o && frame_o[11:10] == 2'(G_RXC)) |-> frame_o[7:0] == rx_ctl)
    else $error("rx control frame carries wrong value");
  status_code_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    status[G_TXA] <= ST_IDLE_FAIL) else $error("status outside legal codes");
  c_send_c: cover property (@(posedge clock_i) state == RRU_SEND && grp == 2'(G_TXA));
  c_ok_c: cover property (@(posedge clock_i) state == RRU_WAIT ##1 status[G_LNK] == ST_IDLE_OK);
  c_fail_c: cover property (@(posedge clock_i) status[G_RXC] == ST_IDLE_FAIL);
  c_loc_c: cover property (@(posedge clock_i) state == RRU_SEND && grp == K_LOCATE);
endmodule

// file: bench/rru_far_model.sv
// far-side link and receiver model: takes frames, answers ack, nack or silence
`timescale 1ns/1ns
module rru_far_model (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [11:0] frame_i,
  input  wire logic        frame_valid_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        slow_i,
  output logic             frame_ready_o,
  output logic             ack_o,
  output logic             nack_o
);
  // mode 0 ack, 1 nack, 2 silent; no hop table is kept, it never crosses the link
  // this side never writes the update registers
  logic [11:0] frames [$];
  int          idle_cnt;
  int          hold_cnt;
  logic        pending;
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_ready_o <= 1'b0;
      ack_o <= 1'b0;
      nack_o <= 1'b0;
      pending <= 1'b0;
      idle_cnt <= 0;
      hold_cnt <= 0;
    end else begin
      // slow mode stalls every other cycle
      frame_ready_o <= slow_i ? ~frame_ready_o : 1'b1;
      if (frame_valid_i && frame_ready_o) begin
        frames.push_back(frame_i);
        pending <= 1'b1;
        idle_cnt <= 0;
      end else if (pending) begin
        idle_cnt <= idle_cnt + 1;
      end
      // answer held six cycles so the three-stage filter sees it
      if (pending && idle_cnt == 3) begin
        pending <= 1'b0;
        hold_cnt <= 6;
        ack_o <= (mode_i == 2'd0);
        nack_o <= (mode_i == 2'd1);
      end else if (hold_cnt > 1) begin
        hold_cnt <= hold_cnt - 1;
      end else begin
        hold_cnt <= 0;
        ack_o <= 1'b0;
        nack_o <= 1'b0;
      end
    end
  end
endmodule

// file: bench/rru_top_tb_top.sv
// self-checking bench for the remote register update engine
`timescale 1ns/1ns
module rru_top_tb_top
  import rru_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [6:0]  addr_i = 7'h00;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  rdata_o;
  logic [11:0] frame_o;
  logic        frame_valid_o;
  logic        frame_ready_i;
  logic        ack_i;
  logic        nack_i;
  logic        link_up_i = 1'b0;
  logic        locate_i = 1'b0;
  logic [7:0]  rx_pins_i = 8'hA5;
  logic [7:0]  tx_fmt_active_o;
  logic [7:0]  tx_lat_active_o;
  logic [7:0]  i2s_in_active_o;
  logic        reconfig_o;
  logic        relink_req_o;
  logic [1:0]  mode = 2'd0;
  logic        slow = 1'b0;
  logic [7:0]  d;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n_reconf = 0;
  int          n_relink = 0;
  rru_top dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frame_o(frame_o),
    .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i), .ack_i(ack_i),
    .nack_i(nack_i), .link_up_i(link_up_i), .locate_i(locate_i), .rx_pins_i(rx_pins_i),
    .tx_fmt_active_o(tx_fmt_active_o), .tx_lat_active_o(tx_lat_active_o),
    .i2s_in_active_o(i2s_in_active_o), .reconfig_o(reconfig_o), .relink_req_o(relink_req_o));
  rru_far_model far (.clock_i(clock_i), .reset_n_i(reset_n_i), .frame_i(frame_o),
    .frame_valid_i(frame_valid_o), .mode_i(mode), .slow_i(slow),
    .frame_ready_o(frame_ready_i), .ack_o(ack_i), .nack_o(nack_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // pulses are counted so a one-cycle output is never missed between bus cycles
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (reconfig_o === 1'b1) n_reconf <= n_reconf + 1;
    if (relink_req_o === 1'b1) n_relink <= n_relink + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask
  // polls until the value shows or the limit runs out
  task automatic poll(input logic [6:0] a, input logic [7:0] exp, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(a, d);
      if (d === exp) break;
    end
  endtask
  task automatic t_reset();
    rd(LNK_UPD_ADDR, d);
    check(d, ST_IDLE_OK);
    rd(TXA_UPD_ADDR, d);
    check(d, ST_IDLE_OK);
    rd(RXC_UPD_ADDR, d);
    check(d, ST_IDLE_OK);
    rd(7'h7F, d);
    check(d, 8'h00);
  endtask
  task automatic t_noop();
    wr(TXA_UPD_ADDR, 8'h02);
    wr(TXA_UPD_ADDR, 8'hFF);
    repeat (20) @(posedge clock_i);
    rd(TXA_UPD_ADDR, d);
    check(d, ST_IDLE_OK);
    check(far.frames.size(), 12'h000);
  endtask
  task automatic t_audio();
    slow <= 1'b1;
    poll(TXA_UPD_ADDR, ST_IDLE_OK, 4);
    wr(TX_FMT_ADDR, 8'h3C);
    wr(TX_LAT_ADDR, 8'h5A);
    wr(I2S_IN_ADDR, 8'h96);
    repeat (10) @(posedge clock_i);
    check(far.frames.size(), 12'h000);
    wr(TXA_UPD_ADDR, CMD_START);
    rd(TXA_UPD_ADDR, d);
    check(d, ST_BUSY);
    poll(TXA_UPD_ADDR, ST_IDLE_OK, 100);
    check(d, ST_IDLE_OK);
    check(far.frames.size(), 12'h003);
    check(far.frames[0], {2'h1, 2'h0, 8'h3C});
    check(far.frames[1], {2'h1, 2'h1, 8'h5A});
    check(far.frames[2], {2'h1, 2'h2, 8'h96});
    check(tx_fmt_active_o, 8'h00);
    slow <= 1'b0;
  endtask
  task automatic t_link_nack();
    mode <= 2'd1;
    far.frames.delete();
    wr(LNK_MODE_ADDR, 8'h21);
    wr(LNK_UPD_ADDR, CMD_START);
    poll(LNK_UPD_ADDR, ST_IDLE_FAIL, 100);
    check(d, ST_IDLE_FAIL);
    check(far.frames.size(), 12'h001);
    check(far.frames[0], {2'h0, 2'h0, 8'h21});
  endtask
  task automatic t_rxc_timeout();
    mode <= 2'd2;
    far.frames.delete();
    wr(RX_CTL_ADDR, 8'h44);
    wr(RX_MODE_ADDR, 8'h07);
    wr(RXC_UPD_ADDR, CMD_START);
    rd(RXC_UPD_ADDR, d);
    check(d, ST_BUSY);
    poll(RXC_UPD_ADDR, ST_IDLE_FAIL, 300);
    check(d, ST_IDLE_FAIL);
    check(far.frames.size(), 12'h001);
    check(far.frames[0], {2'h2, 2'h0, 8'h44});
    mode <= 2'd0;
  endtask
  task automatic t_reconfig();
    link_up_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    check(n_reconf, 12'h001);
    check(tx_fmt_active_o, 8'h3C);
    check(tx_lat_active_o, 8'h5A);
    check(i2s_in_active_o, 8'h96);
    link_up_i <= 1'b0;
  endtask
  task automatic t_force();
    wr(LNK_MODE_ADDR, 8'h10);
    repeat (10) @(posedge clock_i);
    check(n_relink, 12'h001);
    rd(LNK_MODE_ADDR, d);
    check(d[FORCE_BIT], 1'b0);
  endtask
  task automatic t_locate();
    far.frames.delete();
    wr(TX_STA_ADDR, 8'h28);
    locate_i <= 1'b1;
    repeat (40) @(posedge clock_i);
    check(far.frames.size(), 12'h002);
    check(far.frames[0], {K_LOCATE, 2'h0, 8'h28});
    check(far.frames[1], {K_LOCATE, 2'h1, 8'h07});
    rd(RX_PIN_ADDR, d);
    check(d, 8'hA5);
    locate_i <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_noop();
    t_audio();
    t_link_nack();
    t_rxc_timeout();
    t_reconfig();
    t_force();
    t_locate();
    close_out();
  end
endmodule
